// file: prc_pkg.sv
// Shared constants and types for the loop reconfiguration scan chain.
// Assumes one system clock for both ends; the scan clock is made by the controller.
package prc_pkg;

  // ----------------------------------------
  // Scan chain layout
  // ----------------------------------------
  localparam int CHAIN_LEN = 144;
  localparam int SEC_W = 18;
  localparam int NUM_DIV = 7;
  localparam int NUM_C = 5;
  localparam int NUM_TAP_DIV = 6;
  localparam int DIV_M = 5;
  localparam int CNT_W = 8;
  localparam int EXT_W = 9;
  localparam int CP_BASE = 126;
  localparam int LF_BASE = 135;
  localparam int F_LO = 0;
  localparam int F_ODD = 8;
  localparam int F_HI = 9;
  localparam int F_BYP = 17;
  localparam logic [7:0] RST_HI = 8'h01;
  localparam logic [7:0] RST_LO = 8'h01;

  // ----------------------------------------
  // Phase taps
  // ----------------------------------------
  localparam int TAP_W = 3;
  localparam logic [2:0] HALF_TAP = 3'h4;
  localparam logic [2:0] PSEL_ALL_C = 3'h6;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int SCK_MAX_MHZ = 100;
  localparam int SCK_MIN_NS = 1000 / SCK_MAX_MHZ;

  // ----------------------------------------
  // Controller register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_PHASE = 8'h08;
  localparam logic [7:0] OFF_DATA0 = 8'h10;
  localparam int DATA_WORDS = 5;
  localparam int CTRL_START = 0;
  localparam int PH_UP = 3;
  localparam int PH_GO = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_GATE = 10'h002,
    ST_LEAD = 10'h004,
    ST_SHIFT = 10'h008,
    ST_UPD = 10'h010,
    ST_UEND = 10'h020,
    ST_WHI = 10'h040,
    ST_WLO = 10'h080,
    ST_RST = 10'h100,
    ST_PEND = 10'h200
  } prc_state_t;

  // Start bit of divider i inside the chain (C4 sits first)
  function automatic int sec_base(input int i);
    return (i < NUM_C) ? (NUM_C - 1 - i) * SEC_W : i * SEC_W;
  endfunction

endpackage

// file: prc_link_if.sv
// Link between the controller and the reconfigurable loop.
// Assumes both ends run on the same system clock; scan_clk is a plain signal.
interface prc_link_if;
  logic scan_clk;
  logic scan_clk_ena;
  logic scan_data;
  logic config_update;
  logic scan_done;
  logic loop_reset;
  logic [2:0] phase_sel;
  logic phase_up;
  logic phase_step;

  modport dev (
    input scan_clk, scan_clk_ena, scan_data, config_update, loop_reset,
    input phase_sel, phase_up, phase_step,
    output scan_done
  );

  modport ctl (
    output scan_clk, scan_clk_ena, scan_data, config_update, loop_reset,
    output phase_sel, phase_up, phase_step,
    input scan_done
  );
endinterface

// file: prc_pll_end.sv
// Reconfigurable loop end: scan chain, update logic, phase taps, dividers.
// Assumes scan signals come from another domain; the VCO is modelled as aclk/8.
//
// Behaviour
// - dividers pick any of eight VCO phases
// - start hold-off gives C minus one periods
// - phase step moves one tap per request
// - chain shifts serial data on scan clock
// - controller raises gate one cycle early
// - capture begins on second rise after gate
// - controller drops gate after 144 bits
// - one-cycle apply strobe loads new settings
// - done flag high until all counters updated
// - each counter updates on its own clock
// - controller resets loop after each scan update, not after a phase step
// - whole sequence repeatable without limit
// - phase redone by stepping, not chain
// - eight-bit high and low counts
// - skip bit gives divide by one
// - without half select fall on rising edge
// - half select falls on VCO falling edge
// - chain order C4 low LSB to filter MSB
// - 18-bit divider sections, 9-bit pump/filter
module prc_pll_end #(
  parameter logic [55:0] START_COUNTS = {7{8'h01}},
  parameter logic [20:0] INIT_TAPS = 21'h00_0000
) (
  input wire logic aclk,
  input wire logic aresetn,
  prc_link_if.dev link,
  output logic [6:0] div_out,
  output logic [8:0] pump_current_setting,
  output logic [8:0] filter_setting
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  for (genvar g = 0; g < prc_pkg::NUM_DIV; g++)
  begin : g_chk
    if (START_COUNTS[g*8 +: 8] == 8'h00)
      $error("Start count must be at least one");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] sck_q;
  logic [8:0] in_w;
  logic [8:0] sy1_q;
  logic [8:0] sy2_q;
  logic sck_rise;
  logic s_ena;
  logic s_dat;
  logic s_cfg;
  logic s_rst;
  logic s_stp;
  logic [2:0] s_sel;
  logic s_up;

  assign in_w = {link.phase_up, link.phase_sel, link.phase_step, link.loop_reset,
                 link.config_update, link.scan_data, link.scan_clk_ena};
  assign s_ena = sy2_q[0];
  assign s_dat = sy2_q[1];
  assign s_cfg = sy2_q[2];
  assign s_rst = sy2_q[3];
  assign s_stp = sy2_q[4];
  assign s_sel = sy2_q[7:5];
  assign s_up = sy2_q[8];
  assign sck_rise = sck_q[1] & ~sck_q[2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_q <= 3'h0;
      sy1_q <= 9'h000;
      sy2_q <= 9'h000;
    end
    else
    begin
      sck_q <= {sck_q[1:0], link.scan_clk};
      sy1_q <= in_w;
      sy2_q <= sy1_q;
    end
  end

  // ----------------------------------------
  // Scan chain and apply
  // ----------------------------------------
  logic [prc_pkg::CHAIN_LEN-1:0] chain_q;
  logic [prc_pkg::CHAIN_LEN-1:0] shadow_q;
  logic ena_prev_q;
  logic apply;

  assign apply = sck_rise & s_cfg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ena_prev_q <= 1'b0;
      chain_q <= '0;
    end
    else if (sck_rise)
    begin
      ena_prev_q <= s_ena;
      if (s_ena && ena_prev_q)
        chain_q <= {s_dat, chain_q[prc_pkg::CHAIN_LEN-1:1]};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shadow_q <= '0;
      pump_current_setting <= 9'h000;
      filter_setting <= 9'h000;
    end
    else if (apply)
    begin
      shadow_q <= chain_q;
      pump_current_setting <= chain_q[prc_pkg::CP_BASE +: prc_pkg::EXT_W];
      filter_setting <= chain_q[prc_pkg::LF_BASE +: prc_pkg::EXT_W];
    end
  end

  // ----------------------------------------
  // VCO phase taps
  // ----------------------------------------
  logic [2:0] ph_q;
  logic [2:0] tap_q [prc_pkg::NUM_DIV];
  logic stp_prev_q;
  logic step;

  assign step = sck_rise & s_stp & ~stp_prev_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ph_q <= 3'h0;
    else
      ph_q <= ph_q + 3'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stp_prev_q <= 1'b0;
      for (int i = 0; i < prc_pkg::NUM_DIV; i++)
        tap_q[i] <= INIT_TAPS[i*prc_pkg::TAP_W +: prc_pkg::TAP_W];
    end
    else
    begin
      if (sck_rise)
        stp_prev_q <= s_stp;
      for (int i = 0; i < prc_pkg::NUM_TAP_DIV; i++)
      begin
        if (step && (s_sel == 3'(i) || (s_sel == prc_pkg::PSEL_ALL_C && i < prc_pkg::NUM_C)))
          tap_q[i] <= s_up ? tap_q[i] + 3'h1 : tap_q[i] - 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Dividers
  // ----------------------------------------
  logic [7:0] hi_q [prc_pkg::NUM_DIV];
  logic [7:0] lo_q [prc_pkg::NUM_DIV];
  logic [8:0] cnt_q [prc_pkg::NUM_DIV];
  logic [7:0] dly_q [prc_pkg::NUM_DIV];
  logic [6:0] byp_q;
  logic [6:0] odd_q;
  logic [6:0] pend_q;
  logic [6:0] rise_w;
  logic [6:0] fall_w;
  logic done_q;
  logic [prc_pkg::SEC_W-1:0] sec_w [prc_pkg::NUM_DIV];

  function automatic logic [8:0] wrap(input logic [8:0] c, input logic [7:0] h,
                                      input logic [7:0] l);
    logic [8:0] nxt;
    nxt = c + 9'h001;
    return (nxt >= ({1'b0, h} + {1'b0, l})) ? 9'h000 : nxt;
  endfunction

  always_comb
  begin
    for (int i = 0; i < prc_pkg::NUM_DIV; i++)
    begin
      rise_w[i] = (ph_q == tap_q[i]);
      fall_w[i] = (ph_q == tap_q[i] + prc_pkg::HALF_TAP);
      sec_w[i] = shadow_q[prc_pkg::sec_base(i) +: prc_pkg::SEC_W];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      byp_q <= 7'h7F;
      odd_q <= 7'h00;
      pend_q <= 7'h00;
      div_out <= 7'h00;
      for (int i = 0; i < prc_pkg::NUM_DIV; i++)
      begin
        hi_q[i] <= prc_pkg::RST_HI;
        lo_q[i] <= prc_pkg::RST_LO;
        cnt_q[i] <= 9'h000;
        dly_q[i] <= START_COUNTS[i*8 +: 8] - 8'h01;
      end
    end
    else if (s_rst)
    begin
      div_out <= 7'h00;
      for (int i = 0; i < prc_pkg::NUM_DIV; i++)
      begin
        cnt_q[i] <= 9'h000;
        dly_q[i] <= START_COUNTS[i*8 +: 8] - 8'h01;
        if (apply)
          pend_q[i] <= 1'b1;
      end
    end
    else
    begin
      for (int i = 0; i < prc_pkg::NUM_DIV; i++)
      begin
        if (rise_w[i])
        begin
          if (dly_q[i] != 8'h00)
          begin
            dly_q[i] <= dly_q[i] - 8'h01;
            div_out[i] <= 1'b0;
          end
          else if (byp_q[i])
            div_out[i] <= 1'b1;
          else
          begin
            div_out[i] <= (cnt_q[i] < {1'b0, hi_q[i]});
            cnt_q[i] <= wrap(cnt_q[i], hi_q[i], lo_q[i]);
          end
          if (pend_q[i])
          begin
            lo_q[i] <= sec_w[i][prc_pkg::F_LO +: prc_pkg::CNT_W];
            hi_q[i] <= sec_w[i][prc_pkg::F_HI +: prc_pkg::CNT_W];
            odd_q[i] <= sec_w[i][prc_pkg::F_ODD];
            byp_q[i] <= sec_w[i][prc_pkg::F_BYP];
            cnt_q[i] <= 9'h000;
            pend_q[i] <= 1'b0;
          end
        end
        else if (fall_w[i] && dly_q[i] == 8'h00)
        begin
          if (byp_q[i])
            div_out[i] <= 1'b0;
          else if (odd_q[i] && cnt_q[i] == {1'b0, hi_q[i]})
            div_out[i] <= 1'b0;
        end
        if (apply)
          pend_q[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Completion flag
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      done_q <= 1'b0;
    else
      done_q <= |pend_q;
  end

  assign link.scan_done = done_q;

endmodule // prc_pll_end

// file: prc_ctl_end.sv
// Reconfiguration controller: AXI4-Lite register slave and scan sequencer.
// Assumes aclk at 10 MHz; the scan clock is derived from aclk and driven out.
module prc_ctl_end #(
  parameter int SCK_HALF = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  prc_link_if.ctl link
);

  if (SCK_HALF < 2 || 2 * SCK_HALF * prc_pkg::CLK_NS < prc_pkg::SCK_MIN_NS)
    $error("SCK_HALF too small");

  // ----------------------------------------
  // Scan clock divider
  // ----------------------------------------
  logic [7:0] div_q;
  logic sck_q;
  logic fall;

  assign fall = sck_q && (div_q == 8'(SCK_HALF - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_q <= 8'h00;
      sck_q <= 1'b0;
    end
    else if (div_q == 8'(SCK_HALF - 1))
    begin
      div_q <= 8'h00;
      sck_q <= ~sck_q;
    end
    else
      div_q <= div_q + 8'h01;
  end

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic aw_got_q;
  logic w_got_q;
  logic wr_do;
  logic [31:0] data_q [prc_pkg::DATA_WORDS];
  logic [3:0] ph_cfg_q;
  logic [1:0] done_s_q;
  prc_pkg::prc_state_t st_q;
  logic start_q;
  logic pgo_q;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        r[b*8 +: 8] = n[b*8 +: 8];
    return r;
  endfunction

  function automatic logic is_data(input logic [7:0] a);
    return a >= prc_pkg::OFF_DATA0 && a < prc_pkg::OFF_DATA0 + 8'(4 * prc_pkg::DATA_WORDS)
           && a[1:0] == 2'h0;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == prc_pkg::OFF_CTRL || a == prc_pkg::OFF_STAT || a == prc_pkg::OFF_PHASE
           || is_data(a);
  endfunction

  assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_do = aw_got_q & w_got_q & ~s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= prc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awa_q) ? prc_pkg::RESP_OKAY : prc_pkg::RESP_DECERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ph_cfg_q <= 4'h0;
      for (int k = 0; k < prc_pkg::DATA_WORDS; k++)
        data_q[k] <= 32'h0000_0000;
    end
    else if (wr_do)
    begin
      if (awa_q == prc_pkg::OFF_PHASE && ws_q[0])
        ph_cfg_q <= wd_q[3:0];
      for (int k = 0; k < prc_pkg::DATA_WORDS; k++)
        if (awa_q == prc_pkg::OFF_DATA0 + 8'(4 * k))
          data_q[k] <= merge(data_q[k], wd_q, ws_q);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= prc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? prc_pkg::RESP_OKAY : prc_pkg::RESP_DECERR;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr == prc_pkg::OFF_STAT)
        s_axi_rdata <= {29'h0000_0000, start_q | pgo_q, done_s_q[1], st_q != prc_pkg::ST_IDLE};
      else if (s_axi_araddr == prc_pkg::OFF_PHASE)
        s_axi_rdata <= {28'h000_0000, ph_cfg_q};
      else if (is_data(s_axi_araddr))
        s_axi_rdata <= data_q[3'((s_axi_araddr - prc_pkg::OFF_DATA0) >> 2)];
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------
  // Scan sequencer
  // ----------------------------------------
  logic [7:0] idx_q;
  logic [159:0] bits_w;

  assign bits_w = {data_q[4], data_q[3], data_q[2], data_q[1], data_q[0]};
  assign link.scan_clk = sck_q;
  assign link.phase_sel = ph_cfg_q[2:0];
  assign link.phase_up = ph_cfg_q[prc_pkg::PH_UP];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      done_s_q <= 2'h0;
    else
      done_s_q <= {done_s_q[0], link.scan_done};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= prc_pkg::ST_IDLE;
      start_q <= 1'b0;
      pgo_q <= 1'b0;
      idx_q <= 8'h00;
      link.scan_clk_ena <= 1'b0;
      link.scan_data <= 1'b0;
      link.config_update <= 1'b0;
      link.loop_reset <= 1'b0;
      link.phase_step <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        prc_pkg::ST_IDLE:
          if (fall && start_q)
          begin
            start_q <= 1'b0;
            link.scan_clk_ena <= 1'b1;
            st_q <= prc_pkg::ST_GATE;
          end
          else if (fall && pgo_q)
          begin
            pgo_q <= 1'b0;
            link.phase_step <= 1'b1;
            st_q <= prc_pkg::ST_PEND;
          end
        prc_pkg::ST_GATE:
          if (fall)
          begin
            link.scan_data <= bits_w[0];
            idx_q <= 8'h01;
            st_q <= prc_pkg::ST_SHIFT;
          end
        prc_pkg::ST_SHIFT:
          if (fall)
          begin
            if (idx_q == 8'(prc_pkg::CHAIN_LEN))
            begin
              link.scan_clk_ena <= 1'b0;
              st_q <= prc_pkg::ST_UPD;
            end
            else
            begin
              link.scan_data <= bits_w[idx_q];
              idx_q <= idx_q + 8'h01;
            end
          end
        prc_pkg::ST_UPD:
          if (fall)
          begin
            link.config_update <= 1'b1;
            st_q <= prc_pkg::ST_UEND;
          end
        prc_pkg::ST_UEND:
          if (fall)
          begin
            link.config_update <= 1'b0;
            st_q <= prc_pkg::ST_WHI;
          end
        prc_pkg::ST_WHI:
          if (done_s_q[1])
            st_q <= prc_pkg::ST_WLO;
        prc_pkg::ST_WLO:
          if (!done_s_q[1] && fall)
          begin
            link.loop_reset <= 1'b1;
            st_q <= prc_pkg::ST_RST;
          end
        prc_pkg::ST_RST:
          if (fall)
          begin
            link.loop_reset <= 1'b0;
            st_q <= prc_pkg::ST_IDLE;
          end
        prc_pkg::ST_PEND:
          if (fall)
          begin
            link.phase_step <= 1'b0;
            st_q <= prc_pkg::ST_IDLE;
          end
        default:
          st_q <= prc_pkg::ST_IDLE;
      endcase
      if (wr_do && awa_q == prc_pkg::OFF_CTRL && ws_q[0] && wd_q[prc_pkg::CTRL_START])
        start_q <= 1'b1;
      if (wr_do && awa_q == prc_pkg::OFF_PHASE && ws_q[0] && wd_q[prc_pkg::PH_GO])
        pgo_q <= 1'b1;
    end
  end

endmodule // prc_ctl_end

// file: prc_link_asserts.sv
// Concurrent checks on the scan link between the controller and loop ends.
// Assumes every link signal is a register on aclk and SCK_HALF matches the controller.
module prc_link_asserts #(
  parameter int SCK_HALF = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scan_clk,
  input wire logic scan_clk_ena,
  input wire logic scan_data,
  input wire logic config_update,
  input wire logic scan_done,
  input wire logic loop_reset,
  input wire logic phase_step
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [7:0] bits_q;
  logic [3:0] upd_q;

  // Bits moved since the gate rose
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bits_q <= 8'h00;
    else if ($rose(scan_clk_ena))
      bits_q <= 8'h00;
    else if ($fell(scan_clk) && scan_clk_ena)
      bits_q <= bits_q + 8'h01;
  end

  // Cycles the apply strobe has stood
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !config_update)
      upd_q <= 4'h0;
    else
      upd_q <= upd_q + 4'h1;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_UPD_WIDTH: assert property (
    $fell(config_update) |-> upd_q == 4'(2 * SCK_HALF))
    else $error("apply strobe width wrong");
  AST_UPD_AFTER_GATE: assert property (
    $rose(config_update) |-> !scan_clk_ena && !$past(scan_clk_ena, 3))
    else $error("apply strobe while gate open");
  AST_CHAIN_LEN: assert property (
    $fell(scan_clk_ena) |-> bits_q == 8'h90)
    else $error("gate dropped after wrong bit count");
  AST_DATA_ON_FALL: assert property (
    $changed(scan_data) |-> $fell(scan_clk))
    else $error("serial data moved off a falling scan edge");
  AST_GATE_LEAD: assert property (
    $rose(scan_clk_ena) |-> $stable(scan_data)[*4])
    else $error("first bit presented too early");
  AST_DONE_AFTER_UPD: assert property (
    $rose(config_update) |-> ##[2:12] $rose(scan_done))
    else $error("busy flag did not follow apply");
  AST_DONE_SHORT: assert property (
    $rose(scan_done) |-> ##[1:12] !scan_done)
    else $error("busy flag stuck high");
  AST_RESET_AFTER: assert property (
    $fell(scan_done) |-> ##[1:16] $rose(loop_reset))
    else $error("loop reset missing after update");
  AST_LRST_WIDTH: assert property (
    $rose(loop_reset) |-> loop_reset[*4] ##1 !loop_reset)
    else $error("loop reset width wrong");
  AST_STEP_WIDTH: assert property (
    $rose(phase_step) |-> phase_step[*4] ##1 !phase_step)
    else $error("phase step width wrong");

  cover property ($fell(scan_done));
  cover property ($rose(phase_step));
  cover property ($fell(scan_clk_ena));
endmodule // prc_link_asserts

// file: testbench.sv
// Self-checking bench: controller and loop ends joined by the link interface.
// Assumes SCK_HALF of 2, so one scan clock period spans four aclk cycles.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] div_out;
  logic [8:0] pump, filt;
  logic [143:0] cap;
  logic sck_p = 1'b0, ena_p = 1'b0;
  int errors = 0, total_checks = 0, ncap = 0, nlr = 0, nst = 0, nsd = 0;

  prc_link_if link ();
  prc_ctl_end #(.SCK_HALF(2)) u_prc_ctl_end (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link(link.ctl));
  prc_pll_end u_prc_pll_end (.aclk(aclk), .aresetn(aresetn), .link(link.dev),
    .div_out(div_out), .pump_current_setting(pump), .filter_setting(filt));
  prc_link_asserts #(.SCK_HALF(2)) u_prc_link_asserts (.aclk(aclk), .aresetn(aresetn),
    .scan_clk(link.scan_clk), .scan_clk_ena(link.scan_clk_ena), .scan_data(link.scan_data),
    .config_update(link.config_update), .scan_done(link.scan_done),
    .loop_reset(link.loop_reset), .phase_step(link.phase_step));

  always #50 aclk = ~aclk;

  // ----------------------------------------
  // Wire-side capture of the serial stream
  // ----------------------------------------
  always @(posedge aclk)
  begin
    sck_p <= link.scan_clk;
    if (link.scan_clk && !sck_p)
    begin
      ena_p <= link.scan_clk_ena;
      if (link.scan_clk_ena && ena_p)
      begin
        cap <= {link.scan_data, cap[143:1]};
        ncap <= ncap + 1;
      end
    end
  end
  always @(posedge link.loop_reset) nlr++;
  always @(posedge link.phase_step) nst++;
  always @(posedge link.scan_done) nsd++;

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tmo(input bit hit);
    if (hit)
    begin
      errors++;
      $display("ERROR wait expected done seen timeout");
      print_verdict();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit ta, tw;
    n = 0;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw) && n < 50)
    begin
      @(posedge aclk);
      n++;
      ta = ta || awready === 1'b1;
      tw = tw || wready === 1'b1;
      awvalid <= !ta;
      wvalid <= !tw;
    end
    while (bvalid !== 1'b1 && n < 50)
    begin
      @(posedge aclk);
      n++;
    end
    bready <= 1'b0;
    tmo(n >= 50);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    bit ta;
    n = 0;
    ta = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ta && n < 50)
    begin
      @(posedge aclk);
      n++;
      ta = arready === 1'b1;
      arvalid <= !ta;
    end
    while (rvalid !== 1'b1 && n < 50)
    begin
      @(posedge aclk);
      n++;
    end
    d = rdata;
    rready <= 1'b0;
    tmo(n >= 50);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  task automatic wait_idle(input bit on_step, input int base);
    logic [31:0] st;
    int n;
    st = 32'h1;
    for (n = 0; (st !== 32'h0 || (on_step ? nst : nlr) == base) && n < 400; n++)
      axi_rd(prc_pkg::OFF_STAT, st, prc_pkg::RESP_OKAY);
    tmo(n >= 400);
  endtask

  task automatic wt(input int i, input logic v, inout int n);
    while (div_out[i] !== v && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic meas(input int i, output int hi, output int per);
    int n, a, b;
    n = 0;
    wt(i, 1'b0, n);
    wt(i, 1'b1, n);
    a = n;
    wt(i, 1'b0, n);
    b = n;
    wt(i, 1'b1, n);
    hi = b - a;
    per = n - a;
    tmo(n >= 200);
  endtask

  // Cycles from a rise of output 1 to the next rise of output 0
  task automatic poff(input int exp);
    int n, a;
    n = 0;
    wt(1, 1'b0, n);
    wt(1, 1'b1, n);
    a = n;
    wt(0, 1'b1, n);
    tmo(n >= 200);
    chk("tap offset", n - a, exp);
  endtask

  task automatic step(input logic [31:0] v, input int exp);
    int b;
    b = nst;
    axi_wr(prc_pkg::OFF_PHASE, v, prc_pkg::RESP_OKAY);
    wait_idle(1'b1, b);
    chk("steps", nst - b, 1);
    chk("phase pins", {28'h0, link.phase_up, link.phase_sel}, v & 32'h0000_000F);
    poff(exp);
  endtask

  task automatic test_regs();
    logic [31:0] d;
    chk("link idle", {link.scan_clk_ena, link.config_update, link.loop_reset}, 0);
    axi_rd(prc_pkg::OFF_STAT, d, prc_pkg::RESP_OKAY);
    chk("status", d, 0);
    axi_wr(prc_pkg::OFF_PHASE, 32'h0000_000D, prc_pkg::RESP_OKAY);
    axi_rd(prc_pkg::OFF_PHASE, d, prc_pkg::RESP_OKAY);
    chk("phase reg", d, 32'h0000_000D);
    axi_wr(8'h40, 32'hFFFF_FFFF, prc_pkg::RESP_DECERR);
    axi_rd(8'h40, d, prc_pkg::RESP_DECERR);
    chk("unmapped", d, 0);
    axi_rd(prc_pkg::OFF_CTRL, d, prc_pkg::RESP_OKAY);
    chk("ctrl", d, 0);
    $display("register test done");
  endtask

  task automatic test_phase();
    int hi, per;
    meas(0, hi, per);
    chk("reset high", hi, 4);
    chk("reset period", per, 8);
    poff(0);
    step(32'h0000_0018, 1);
    step(32'h0000_001E, 1);
    step(32'h0000_0010, 0);
    $display("phase test done");
  endtask

  task automatic run_scan(input logic [7:0] h, input logic [7:0] l, input logic [1:0] mode,
                          input int ehi, input int eper);
    logic [159:0] c;
    int b, s, hi, per;
    c = '0;
    for (int k = 0; k < 7; k++) c[18 * k + 17] = 1'b1;
    c[72 +: 18] = {mode[1], h, mode[0], l};
    c[126 +: 9] = {1'b1, h};
    c[135 +: 9] = {l, 1'b0};
    for (int k = 0; k < 5; k++)
      axi_wr(prc_pkg::OFF_DATA0 + 8'(4 * k), c[32 * k +: 32], prc_pkg::RESP_OKAY);
    b = nlr;
    s = nsd;
    ncap = 0;
    axi_wr(prc_pkg::OFF_CTRL, 32'h0000_0001, prc_pkg::RESP_OKAY);
    wait_idle(1'b0, b);
    for (int k = 0; k < 5; k++) chk("chain", {16'h0, cap} >> (32 * k), c >> (32 * k));
    chk("bits", ncap, 144);
    chk("done pulses", nsd - s, 1);
    chk("pump", pump, {1'b1, h});
    chk("filter", filt, {l, 1'b0});
    meas(0, hi, per);
    chk("high time", hi, ehi);
    chk("period", per, eper);
    $display("scan test done");
  endtask

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_phase();
    run_scan(8'h02, 8'h01, 2'b00, 16, 24);
    run_scan(8'h02, 8'h01, 2'b01, 12, 24);
    run_scan(8'h03, 8'h05, 2'b10, 4, 8);
    run_scan(8'h03, 8'h05, 2'b00, 24, 64);
    print_verdict();
  end
endmodule // testbench
